// file: hw/analog_select_and_reset_input.sv
// Purpose: analog terminal select and reset input handling for a motor drive
// Assumes: terminals synchronous to mclk; settings stable while used
// Notes: trip and run commands come from the drive core
//
// Notes on behaviour
// - active select with setting 00 enables current terminal pair, 4-20 mA
// - active select with setting 01 enables second voltage terminal pair
// - inactive select enables primary voltage pair, either setting value
// - bipolar range setting decides whether analog reference may reverse
// - current reference never bipolar; direction from forward/reverse run commands
// - analog select acts only when frequency source setting is 01
// - select uses code 16, reset code 18, on any of five inputs
// - reset executed during trip leaves the trip state
// - in leading-edge mode, alarm output drops within 30 ms of reset command start
// - while reset active: motor off, trip cleared, powerup reset applied
// - run command still active after reset restarts motor at once
// - reset acts on leading or trailing edge per reset edge setting
// - reset input works only normally open; closed polarity refused
// - input power on performs the same reset as a reset pulse
// - reset held over 4 s at powerup shows error until release and key
`timescale 1ns/1ps
module analog_select_and_reset_input #(
  parameter longint HELD_CYC = input_func_pkg::HELD_CYC,
  parameter int RESET_MIN_CYC = input_func_pkg::RESET_MIN_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // intelligent input terminals and their assignment
  input wire logic [4:0] input_terminals,
  input wire logic [24:0] input_option_codes,
  input wire logic [4:0] input_normally_closed,
  // settings
  input wire logic [1:0] analog_select_setting,
  input wire logic [1:0] bipolar_range_setting,
  input wire logic [1:0] frequency_source_setting,
  input wire logic reset_edge_setting,
  // drive core status
  input wire logic trip_event,
  input wire logic forward_run_command,
  input wire logic reverse_run_command,
  input wire logic operator_key,
  // analog routing
  output input_func_pkg::analog_route_t analog_route,
  // run, trip and alarm
  output logic motor_output_enable,
  output logic run_reverse,
  output logic trip_state,
  output logic alarm_output,
  output logic core_reset,
  output logic comm_error_display,
  output logic config_error
);
  // ----------------------------------------
  // input assignment decode
  // ----------------------------------------
  function automatic logic [4:0] assigned(input logic [24:0] codes, input logic [4:0] code);
    logic [4:0] hit;
    hit = 5'h0;
    for (int i = 0; i < input_func_pkg::NUM_INPUTS; i++) begin
      hit[i] = (codes[i*5 +: 5] == code);
    end
    return hit;
  endfunction

  wire [4:0] asel_hit = assigned(input_option_codes, input_func_pkg::OPT_ANALOG_SELECT);
  wire [4:0] rst_hit = assigned(input_option_codes, input_func_pkg::OPT_RESET);
  // polarity applies to ordinary inputs; reset ignores the closed flag
  wire [4:0] level_in = input_terminals ^ input_normally_closed;
  wire analog_select_input = |(asel_hit & level_in);
  wire reset_terminal_raw = |(rst_hit & input_terminals);
  wire bad_polarity = |(rst_hit & input_normally_closed);

  // ----------------------------------------
  // analog routing
  // ----------------------------------------
  wire from_terminals = (frequency_source_setting == input_func_pkg::FREQ_SRC_TERMINAL);
  wire use_current = from_terminals && analog_select_input &&
    (analog_select_setting == input_func_pkg::ASEL_CURRENT);
  wire use_volt2 = from_terminals && analog_select_input &&
    (analog_select_setting == input_func_pkg::ASEL_VOLT2);
  wire [2:0] next_terminal = use_current ? input_func_pkg::TERM_CURRENT :
    use_volt2 ? input_func_pkg::TERM_VOLT2 : input_func_pkg::TERM_VOLT1;
  wire next_bipolar = !use_current &&
    (bipolar_range_setting != input_func_pkg::BIPOLAR_OFF);

  always_ff @(posedge mclk) begin
    if (rst) begin
      analog_route <= '0;
    end else begin
      analog_route.terminal <= next_terminal;
      analog_route.bipolar <= next_bipolar;
      analog_route.active <= from_terminals;
    end
  end

  // ----------------------------------------
  // reset input filter and edge
  // ----------------------------------------
  logic reset_clean;
  logic reset_prev;
  pulse_filter #(.MIN_CYC(RESET_MIN_CYC)) u_filter (
    .mclk(mclk),
    .rst(rst),
    .raw(reset_terminal_raw),
    .clean(reset_clean)
  );

  always_ff @(posedge mclk) begin
    reset_prev <= rst ? 1'b0 : reset_clean;
  end

  wire rise = reset_clean && !reset_prev;
  wire fall = !reset_clean && reset_prev;
  wire reset_edge = reset_edge_setting ? fall : rise;

  // ----------------------------------------
  // reset sequencer
  // ----------------------------------------
  input_func_pkg::reset_state_t state;
  input_func_pkg::reset_state_t next_state;
  logic [39:0] held_cnt;
  wire held_long = (held_cnt >= 40'(HELD_CYC));

  always_comb begin
    next_state = state;
    case (state)
      input_func_pkg::ST_POWERUP: begin
        // filter starts low after rst, so the raw pin must agree before leaving
        if (!reset_clean && !reset_terminal_raw) begin
          next_state = input_func_pkg::ST_RUN;
        end else if (held_long) begin
          next_state = input_func_pkg::ST_HELD_ERR;
        end
      end
      input_func_pkg::ST_RUN: begin
        if (reset_edge || (reset_clean && !reset_edge_setting)) begin
          next_state = input_func_pkg::ST_RESET;
        end
      end
      input_func_pkg::ST_RESET: begin
        // trailing-edge mode resets for one cycle; leading-edge holds while on
        if (reset_edge_setting || !reset_clean) begin
          next_state = input_func_pkg::ST_RUN;
        end
      end
      input_func_pkg::ST_HELD_ERR: begin
        // core restarts on release; the display waits for a key
        if (!reset_clean) begin
          next_state = input_func_pkg::ST_RUN;
        end
      end
      default: next_state = input_func_pkg::ST_POWERUP;
    endcase
  end

  always_ff @(posedge mclk) begin
    state <= rst ? input_func_pkg::ST_POWERUP : next_state;
  end

  // long count only meaningful during powerup
  always_ff @(posedge mclk) begin
    if (rst || state != input_func_pkg::ST_POWERUP) begin
      held_cnt <= 40'h0;
    end else if (reset_clean && !held_long) begin
      held_cnt <= held_cnt + 40'h1;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  wire in_powerup = (state == input_func_pkg::ST_POWERUP);
  wire resetting = (next_state != input_func_pkg::ST_RUN);
  // powerup keeps core reset up for the cycle in which the pin is judged
  wire holding = resetting || in_powerup;
  wire run_cmd = forward_run_command ^ reverse_run_command;

  always_ff @(posedge mclk) begin
    if (rst) begin
      trip_state <= 1'b0;
      alarm_output <= 1'b0;
    end else if (resetting) begin
      trip_state <= 1'b0;
      alarm_output <= 1'b0;
    end else if (trip_event) begin
      trip_state <= 1'b1;
      alarm_output <= 1'b1;
    end
  end

  // run resumes straight away if still commanded once reset ends
  always_ff @(posedge mclk) begin
    if (rst) begin
      motor_output_enable <= 1'b0;
      run_reverse <= 1'b0;
      core_reset <= 1'b1;
    end else begin
      motor_output_enable <= !holding && !trip_state && !trip_event && run_cmd
        && !bad_polarity;
      run_reverse <= reverse_run_command && !forward_run_command;
      core_reset <= holding;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      comm_error_display <= 1'b0;
    end else if (state == input_func_pkg::ST_HELD_ERR) begin
      comm_error_display <= 1'b1;
    end else if (!reset_clean && operator_key) begin
      comm_error_display <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    config_error <= rst ? 1'b0 : bad_polarity;
  end

endmodule

// file: hw/input_func_pkg.sv
// Purpose: shared constants and types for the analog select and reset input block
// Assumes: mclk at 100 MHz
// Notes: option codes and setting encodings live here
package input_func_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 100000000;
  localparam int RESET_MIN_MS = 12;
  localparam int ALARM_CLEAR_MS = 30;
  localparam int HELD_AT_POWERUP_S = 4;
  localparam int RESET_MIN_CYC = (RESET_MIN_MS * (CLK_HZ / 1000));
  localparam int ALARM_CLEAR_CYC = (ALARM_CLEAR_MS * (CLK_HZ / 1000));
  localparam longint HELD_CYC = longint'(HELD_AT_POWERUP_S) * longint'(CLK_HZ);
  localparam int CNT_W = 32;
  // ----------------------------------------
  // option codes and settings
  // ----------------------------------------
  localparam logic [4:0] OPT_ANALOG_SELECT = 5'h10;
  localparam logic [4:0] OPT_RESET = 5'h12;
  localparam int NUM_INPUTS = 5;
  localparam logic [1:0] ASEL_CURRENT = 2'h0;
  localparam logic [1:0] ASEL_VOLT2 = 2'h1;
  localparam logic [1:0] BIPOLAR_OFF = 2'h0;
  localparam logic [1:0] FREQ_SRC_TERMINAL = 2'h1;
  localparam logic [2:0] TERM_VOLT1 = 3'h1;
  localparam logic [2:0] TERM_CURRENT = 3'h2;
  localparam logic [2:0] TERM_VOLT2 = 3'h4;

  typedef struct packed {
    logic [2:0] terminal;
    logic bipolar;
    logic active;
  } analog_route_t;

  typedef enum logic [3:0] {
    ST_POWERUP = 4'h1,
    ST_RUN = 4'h2,
    ST_RESET = 4'h4,
    ST_HELD_ERR = 4'h8
  } reset_state_t;
endpackage

// file: hw/pulse_filter.sv
// Purpose: qualify a raw contact level with a minimum-width filter
// Assumes: input synchronous to mclk
// Notes: output follows input only after it is stable for MIN_CYC cycles
`timescale 1ns/1ps
module pulse_filter #(
  parameter int MIN_CYC = 1200000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // level
  input wire logic raw,
  output logic clean
);
  logic [31:0] cnt;
  logic stage;
  wire differs = (stage != clean);
  wire done = (cnt >= 32'(MIN_CYC - 1));

  // two stages so the filter never sees a metastable first stage
  logic meta;
  always_ff @(posedge mclk) begin
    meta <= rst ? 1'b0 : raw;
    stage <= rst ? 1'b0 : meta;
  end

  always_ff @(posedge mclk) begin
    if (rst || !differs) begin
      cnt <= 32'h0;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      clean <= 1'b0;
    end else if (differs && done) begin
      clean <= stage;
    end
  end
endmodule

// file: verification/analog_select_and_reset_input_monitor.sv
// Purpose: port-level checks for analog select and reset input
// Assumes: one clock domain, rst synchronous
// Notes: bound into every instance of the block
`timescale 1ns/1ps
module analog_select_and_reset_input_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // settings
  input wire logic [1:0] bipolar_range_setting,
  input wire logic [1:0] frequency_source_setting,
  // outputs watched
  input wire input_func_pkg::analog_route_t analog_route,
  input wire logic motor_output_enable,
  input wire logic trip_state,
  input wire logic alarm_output,
  input wire logic core_reset,
  input wire logic config_error
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ----
  // sequences
  // ----
  sequence s_reset_held;
    core_reset ##1 core_reset;
  endsequence
  sequence s_src_off;
    (frequency_source_setting != input_func_pkg::FREQ_SRC_TERMINAL) [*3];
  endsequence
  AST_CUR_UNIPOLAR: assert property (analog_route.terminal == input_func_pkg::TERM_CURRENT
    |-> !analog_route.bipolar) else $error("current route shown bipolar");
  AST_SRC_GATE: assert property (s_src_off
    |=> analog_route.terminal == input_func_pkg::TERM_VOLT1 && !analog_route.active)
    else $error("route changed without terminal frequency source");
  AST_BIP_OFF: assert property ((bipolar_range_setting == input_func_pkg::BIPOLAR_OFF) [*3]
    |=> !analog_route.bipolar) else $error("bipolar with range setting off");
  AST_PWR_RESET: assert property ($fell(rst) |-> s_reset_held)
    else $error("no reset sequence after power on");
  AST_MOTOR_OFF: assert property (s_reset_held |-> !motor_output_enable)
    else $error("motor on during reset");
  AST_RESET_NO_TRIP: assert property (s_reset_held |-> !trip_state && !alarm_output)
    else $error("trip or alarm kept during reset");
  AST_TRIP_CLR: assert property ($rose(core_reset) |-> ##[0:2] (!trip_state && !alarm_output))
    else $error("trip or alarm not cleared by reset");
  AST_CFG_BLOCK: assert property (config_error [*2] |-> !motor_output_enable)
    else $error("motor on with closed polarity reset input");
endmodule
bind analog_select_and_reset_input analog_select_and_reset_input_monitor mon (.mclk, .rst,
  .bipolar_range_setting, .frequency_source_setting, .analog_route, .motor_output_enable,
  .trip_state, .alarm_output, .core_reset, .config_error);

// file: verification/analog_select_and_reset_input_test.sv
// Purpose: self-checking bench for analog select and reset input
// Assumes: shortened filter and powerup-hold counts
// Notes: reset on input 0 and analog select on input 1 unless moved
`timescale 1ns/1ps
module analog_select_and_reset_input_test;
  localparam int MIN = 20;
  localparam logic [24:0] CODES = {15'h0, input_func_pkg::OPT_ANALOG_SELECT,
    input_func_pkg::OPT_RESET};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] input_terminals;
  logic [24:0] input_option_codes = CODES;
  logic [4:0] input_normally_closed = 5'h00;
  logic [1:0] analog_select_setting = 2'h0;
  logic [1:0] bipolar_range_setting = 2'h0;
  logic [1:0] frequency_source_setting = 2'h1;
  logic reset_edge_setting = 1'b0;
  logic trip_event = 1'b0;
  logic forward_run_command = 1'b0;
  logic reverse_run_command = 1'b0;
  logic operator_key = 1'b0;
  input_func_pkg::analog_route_t analog_route;
  logic motor_output_enable, run_reverse, trip_state, alarm_output;
  logic core_reset, comm_error_display, config_error;
  int fail_count = 0;
  int n_checks = 0;
  always #5 mclk = ~mclk;
  contact_model ext (.mclk, .pins(input_terminals));
  analog_select_and_reset_input #(.HELD_CYC(200), .RESET_MIN_CYC(MIN)) dut (.mclk, .rst,
    .input_terminals, .input_option_codes, .input_normally_closed, .analog_select_setting,
    .bipolar_range_setting, .frequency_source_setting, .reset_edge_setting, .trip_event,
    .forward_run_command, .reverse_run_command, .operator_key, .analog_route,
    .motor_output_enable, .run_reverse, .trip_state, .alarm_output, .core_reset,
    .comm_error_display, .config_error);
  // ----
  // helpers
  // ----
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [2:0] exp, input logic [2:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // a wait that runs out ends the run at once
  task automatic wait_cr(input logic v, input int lim);
    for (int i = 0; i < lim && core_reset !== v; i++) tick(1);
    chk("core_reset", v, core_reset);
    if (core_reset !== v) give_verdict();
  endtask
  task automatic trip_pulse();
    trip_event = 1'b1;
    tick(1);
    trip_event = 1'b0;
    tick(1);
  endtask
  task automatic watch(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < MIN + 10; i++) begin
      seen |= core_reset;
      tick(1);
    end
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_route();
    int f, a, s, b;
    logic [2:0] et;
    for (int k = 0; k < 24; k++) begin
      f = k / 12;
      a = (k / 6) % 2;
      s = (k / 3) % 2;
      b = k % 3;
      frequency_source_setting = 2'(f);
      analog_select_setting = 2'(s);
      bipolar_range_setting = 2'(b);
      ext.level(1, a[0]);
      tick(3);
      et = (s == 0) ? input_func_pkg::TERM_CURRENT : input_func_pkg::TERM_VOLT2;
      if (f == 0 || a == 0) et = input_func_pkg::TERM_VOLT1;
      chk("terminal", et, analog_route.terminal);
      if (f == 1) chk("bipolar", et != 3'h2 && b != 0, analog_route.bipolar);
      chk("active", 3'(f), analog_route.active);
    end
  endtask
  task automatic t_lead();
    forward_run_command = 1'b1;
    trip_pulse();
    chk("trip", 3'h1, trip_state);
    ext.level(0, 1'b1);
    for (int n = 0; n < MIN + 10 && alarm_output !== 1'b0; n++) tick(1);
    tick(1);
    chk("alarm", 3'h0, alarm_output);
    chk("trip", 3'h0, trip_state);
    chk("motor", 3'h0, motor_output_enable);
    ext.level(0, 1'b0);
    wait_cr(1'b0, MIN + 10);
    tick(3);
    chk("motor", 3'h1, motor_output_enable);
    forward_run_command = 1'b0;
    reverse_run_command = 1'b1;
    tick(2);
    chk("reverse", 3'h1, run_reverse);
    chk("motor", 3'h1, motor_output_enable);
    reverse_run_command = 1'b0;
    tick(2);
    chk("reverse", 3'h0, run_reverse);
    chk("motor", 3'h0, motor_output_enable);
  endtask
  task automatic t_short();
    logic seen;
    ext.hold(0, MIN / 4);
    watch(seen);
    chk("short pulse", 3'h0, seen);
  endtask
  task automatic t_trail();
    logic seen;
    input_option_codes = {input_func_pkg::OPT_RESET, 20'h0};
    reset_edge_setting = 1'b1;
    trip_pulse();
    ext.level(4, 1'b1);
    watch(seen);
    chk("reset while on", 3'h0, seen);
    ext.level(4, 1'b0);
    wait_cr(1'b1, MIN + 10);
    tick(2);
    chk("core_reset", 3'h0, core_reset);
    chk("trip", 3'h0, trip_state);
    reset_edge_setting = 1'b0;
    input_option_codes = CODES;
  endtask
  task automatic t_nc();
    input_normally_closed = 5'h01;
    forward_run_command = 1'b1;
    tick(4);
    chk("config", 3'h1, config_error);
    chk("motor", 3'h0, motor_output_enable);
    input_normally_closed = 5'h00;
    tick(4);
    chk("motor", 3'h1, motor_output_enable);
    forward_run_command = 1'b0;
  endtask
  task automatic t_held();
    rst = 1'b1;
    ext.level(0, 1'b1);
    tick(2);
    rst = 1'b0;
    for (int i = 0; i < 400 && comm_error_display !== 1'b1; i++) tick(1);
    chk("comm error", 3'h1, comm_error_display);
    ext.level(0, 1'b0);
    wait_cr(1'b0, MIN + 10);
    chk("comm error", 3'h1, comm_error_display);
    operator_key = 1'b1;
    tick(3);
    chk("comm error", 3'h0, comm_error_display);
    operator_key = 1'b0;
  endtask
  initial begin
    tick(16);
    rst = 1'b0;
    tick(1);
    chk("core_reset", 3'h1, core_reset);
    wait_cr(1'b0, MIN + 10);
    t_route();
    t_lead();
    t_short();
    t_trail();
    t_nc();
    t_held();
    give_verdict();
  end
endmodule

// file: verification/contact_model.sv
// Purpose: external contacts driving the intelligent input terminals
// Assumes: changes land on falling edges of mclk
// Notes: levels only; no bounce modelled
`timescale 1ns/1ps
module contact_model (
  // clock
  input wire logic mclk,
  // terminals
  output logic [4:0] pins
);
  initial pins = 5'h00;
  task automatic level(input int idx, input logic v);
    @(negedge mclk);
    pins[idx] = v;
  endtask
  // short widths only when a scenario asks for a rejected pulse
  task automatic hold(input int idx, input int cyc);
    level(idx, 1'b1);
    repeat (cyc) @(negedge mclk);
    pins[idx] = 1'b0;
  endtask
endmodule
